// ===== design/scmc_defs.vh
`ifndef SCMC_DEFS_VH
`define SCMC_DEFS_VH
// operating mode codes
`define SCMC_MODE_SLAVE   3'h0
`define SCMC_MODE_MASTER  3'h1
`define SCMC_MODE_TRIGGER 3'h2
`define SCMC_MODE_AUTO    3'h3
`define SCMC_MODE_PIN     3'h4
`define SCMC_MODE_ANY     3'h5
`define SCMC_MODE_PAIR    3'h6
// characters
`define SCMC_CH_ESC   8'h24
`define SCMC_CH_DASH  8'h2d
`define SCMC_CH_CR    8'h0d
`define SCMC_CH_QUERY 8'h3f
// reply codes on reply_code_o
`define SCMC_RPL_NONE  3'h0
`define SCMC_RPL_CMD   3'h1
`define SCMC_RPL_AOK   3'h2
`define SCMC_RPL_ERR   3'h3
`define SCMC_RPL_QUERY 3'h4
`define SCMC_RPL_HELP  3'h5
`define SCMC_RPL_SET   3'h6
`define SCMC_RPL_END   3'h7
// command classes from the external parser
`define SCMC_CC_VALID   3'h0
`define SCMC_CC_INVALID 3'h1
`define SCMC_CC_UNKNOWN 3'h2
`define SCMC_CC_HELP    3'h3
`define SCMC_CC_SHOW    3'h4
// defaults and timing
`define SCMC_CFG_TIME_DEF 8'd60
`define SCMC_CFG_TIME_INF 8'd255
`define SCMC_BAUD_DEF     115200
`define SCMC_CLK_HZ       25000000
`endif

// ===== design/scmc_ctrl.v
`include "scmc_defs.vh"
module scmc_ctrl #(
  parameter CLK_HZ   = `SCMC_CLK_HZ,
  parameter BAUD_DEF = `SCMC_BAUD_DEF
) (
  // clock and reset
  input  wire       core_clk_i,
  input  wire       rst_i,
  // uart receive stream
  input  wire       rx_valid_i,
  input  wire [7:0] rx_data_i,
  // command parser verdict for a finished line
  input  wire       cmd_done_i,
  input  wire [2:0] cmd_class_i,
  input  wire       cmd_connect_i,
  // stored settings; new mode and timeout values held until reboot, address valid and break used live
  input  wire [2:0] operating_mode_select_i,
  input  wire [7:0] config_timeout_set_i,
  input  wire [7:0] idle_timeout_set_i,
  input  wire       remote_address_valid_i,
  input  wire       break_seen_i,
  // link status and pin
  input  wire       link_up_i,
  input  wire       inquiry_found_i,
  input  wire       connect_control_pin_i,
  // data path
  output reg        tx_valid_o,
  output reg  [7:0] tx_data_o,
  output reg        reply_valid_o,
  output reg  [2:0] reply_code_o,
  // mode and link control
  output reg        cmd_mode_o,
  output reg        fast_data_o,
  output reg        connect_req_o,
  output reg        disconnect_req_o,
  output reg        inquiry_req_o,
  output reg        store_address_o,
  output reg        discoverable_o,
  output reg        remote_config_ok_o,
  output reg  [2:0] active_mode_o,
  output reg [31:0] baud_rate_o
);

  // one second in core clock cycles; a bench may shrink CLK_HZ so that
  // the configuration window and idle timeouts run out in a short run
  // limitation: the second is counted in whole cycles, so any fraction
  // of a cycle in CLK_HZ is lost and the window runs slightly short
  localparam [31:0] SEC_CYC = CLK_HZ;

  // one-hot escape tracker
  localparam [3:0] ST_IDLE = 4'b0001;
  localparam [3:0] ST_ONE  = 4'b0010;
  localparam [3:0] ST_TWO  = 4'b0100;
  localparam [3:0] ST_CMD  = 4'b1000;

  // modes that connect by themselves and pass data uninterpreted
  function is_auto;
    input [2:0] m;
    is_auto = (m == `SCMC_MODE_AUTO) || (m == `SCMC_MODE_PIN) || (m == `SCMC_MODE_ANY);
  endfunction

  // every mode but slave starts links itself and hides from inquiry
  function is_master;
    input [2:0] m;
    is_master = (m != `SCMC_MODE_SLAVE);
  endfunction

  ////////////////////////////////////////////////////////////////////////
  reg  [3:0]  st_q;
  reg  [1:0]  dash_q;
  reg  [31:0] tick_q;
  reg  [7:0]  sec_q;
  reg  [7:0]  idle_q;
  reg         win_open_q;
  reg         boot_q;
  reg         pin_q;
  reg  [2:0]  mode_q;
  reg  [7:0]  cfg_q;
  reg  [7:0]  idle_set_q;
  reg         sec_pulse;
  wire        entry_ok;

  // settings latched once after reset; later changes wait for reboot
  // the parser may already read back a new value, but the behaviour
  // seen here is frozen until the next reset, so a mode change never
  // lands in the middle of a connection or an escape sequence
  // an idle timeout of zero is taken as one second, since a zero
  // would drop a trigger link in the very cycle it came up
  always @(posedge core_clk_i) begin
    if (rst_i) begin
      boot_q <= 1'b1;
      mode_q <= `SCMC_MODE_SLAVE;
      cfg_q  <= `SCMC_CFG_TIME_DEF;
      idle_set_q <= 8'h01;
    end else if (boot_q) begin
      boot_q <= 1'b0;
      // out-of-range values fall back to slave
      mode_q <= (operating_mode_select_i > `SCMC_MODE_PAIR) ? `SCMC_MODE_SLAVE
                : operating_mode_select_i;
      cfg_q  <= config_timeout_set_i;
      idle_set_q <= (idle_timeout_set_i == 8'h00) ? 8'h01 : idle_timeout_set_i;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // seconds tick restarting at boot
  // a single free-running prescaler feeds both the configuration window
  // and the trigger idle timer, which trades a shared phase (up to one
  // second of jitter on the idle timeout) for one wide counter only
  always @(posedge core_clk_i) begin
    if (rst_i) begin
      tick_q    <= 32'h0;
      sec_pulse <= 1'b0;
    end else if (tick_q == SEC_CYC - 32'h1) begin
      tick_q    <= 32'h0;
      sec_pulse <= 1'b1;
    end else begin
      tick_q    <= tick_q + 32'h1;
      sec_pulse <= 1'b0;
    end
  end

  // configuration window; 255 keeps it open forever
  // the window only ever closes: once shut it stays shut until reset,
  // so a late escape can never reopen configuration access
  // the count holds while the window is infinite, so it cannot wrap
  always @(posedge core_clk_i) begin
    if (rst_i) begin
      sec_q      <= 8'h0;
      win_open_q <= 1'b1;
    end else if (!boot_q && sec_pulse && win_open_q && cfg_q != `SCMC_CFG_TIME_INF) begin
      sec_q <= sec_q + 8'h1;
      if (sec_q + 8'h1 >= cfg_q)
        win_open_q <= 1'b0;
    end
  end

  // connected needs an open window; auto modes never when connected
  // this one term gates both local escape entry and the remote
  // configuration grant, and the grant is further limited to slave mode
  assign entry_ok = !fast_data_o &&
                    (!link_up_i || win_open_q) &&
                    !(is_auto(mode_q) && link_up_i);

  ////////////////////////////////////////////////////////////////////////
  // escape detection, command mode, fast data fallback
  // the tracker holds at most two escape characters; a third one in a
  // row completes the sequence, anything else breaks it
  // hazard: escape bytes are swallowed while counted, so a host that
  // sends a lone escape followed by data loses that escape byte
  // fast data is entered only outside command mode: a user already
  // configuring when the window runs out keeps the session
  // in command mode every received byte is fed to the dash counter,
  // and the parser verdict is only honoured in a cycle with no byte
  always @(posedge core_clk_i) begin
    if (rst_i) begin
      st_q          <= ST_IDLE;
      dash_q        <= 2'h0;
      cmd_mode_o    <= 1'b0;
      fast_data_o   <= 1'b0;
      tx_valid_o    <= 1'b0;
      tx_data_o     <= 8'h00;
      reply_valid_o <= 1'b0;
      reply_code_o  <= `SCMC_RPL_NONE;
    end else begin
      tx_valid_o    <= 1'b0;
      reply_valid_o <= 1'b0;
      if (!win_open_q && st_q != ST_CMD)
        fast_data_o <= 1'b1;
      case (st_q)
        ST_IDLE, ST_ONE, ST_TWO: begin
          if (rx_valid_i) begin
            if (rx_data_i == `SCMC_CH_ESC && entry_ok && !is_auto(mode_q)) begin
              if (st_q == ST_TWO) begin
                st_q          <= ST_CMD;
                cmd_mode_o    <= 1'b1;
                dash_q        <= 2'h0;
                reply_valid_o <= 1'b1;
                reply_code_o  <= `SCMC_RPL_CMD;
              end else begin
                st_q <= (st_q == ST_IDLE) ? ST_ONE : ST_TWO;
              end
            end else begin
              // flush held prefix count: forward only this byte, the held
              // escape bytes are discarded and never re-sent
              st_q       <= ST_IDLE;
              tx_valid_o <= 1'b1;
              tx_data_o  <= rx_data_i;
            end
          end
        end
        ST_CMD: begin
          if (link_up_i && is_auto(mode_q)) begin
            st_q       <= ST_IDLE;
            cmd_mode_o <= 1'b0;
          end else if (rx_valid_i) begin
            if (rx_data_i == `SCMC_CH_DASH)
              dash_q <= (dash_q == 2'h3) ? 2'h3 : dash_q + 2'h1;
            else if (rx_data_i == `SCMC_CH_CR && dash_q == 2'h3) begin
              st_q          <= ST_IDLE;
              cmd_mode_o    <= 1'b0;
              reply_valid_o <= 1'b1;
              reply_code_o  <= `SCMC_RPL_END;
            end else
              dash_q <= 2'h0;
          end else if (cmd_done_i) begin
            reply_valid_o <= 1'b1;
            case (cmd_class_i)
              `SCMC_CC_VALID:   reply_code_o <= `SCMC_RPL_AOK;
              `SCMC_CC_INVALID: reply_code_o <= `SCMC_RPL_ERR;
              `SCMC_CC_HELP:    reply_code_o <= `SCMC_RPL_HELP;
              `SCMC_CC_SHOW:    reply_code_o <= `SCMC_RPL_SET;
              default:          reply_code_o <= `SCMC_RPL_QUERY;
            endcase
          end
        end
        default: st_q <= ST_IDLE;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // connection control per operating mode
  // every request is a level repeated each cycle while its condition
  // holds; the link layer is expected to ignore repeats while busy
  // discoverability and remote access follow the latched mode only,
  // so a mode set by command shows after the next reboot
  // auto master mode has no disconnect path at all: neither the break
  // input nor a command can drop its link
  // any mode reacts to the rising edge of the pin, so holding the pin
  // high starts exactly one inquiry; the found address is never stored
  // pin mode follows the pin level, so a pin stuck high keeps retrying
  // idle time counts whole seconds without received bytes and is
  // cleared while the link is down, so a new link starts from zero
  always @(posedge core_clk_i) begin
    if (rst_i) begin
      pin_q            <= 1'b0;
      idle_q           <= 8'h0;
      connect_req_o    <= 1'b0;
      disconnect_req_o <= 1'b0;
      inquiry_req_o    <= 1'b0;
      store_address_o  <= 1'b0;
      discoverable_o   <= 1'b0;
      remote_config_ok_o <= 1'b0;
      active_mode_o    <= `SCMC_MODE_SLAVE;
      baud_rate_o      <= 32'h0;
    end else begin
      pin_q            <= connect_control_pin_i;
      connect_req_o    <= 1'b0;
      disconnect_req_o <= 1'b0;
      inquiry_req_o    <= 1'b0;
      store_address_o  <= 1'b0;
      active_mode_o    <= mode_q;
      baud_rate_o      <= BAUD_DEF;
      discoverable_o   <= !is_master(mode_q);
      remote_config_ok_o <= !is_master(mode_q) && entry_ok;
      if (rx_valid_i || !link_up_i)
        idle_q <= 8'h0;
      else if (sec_pulse && idle_q != 8'hff)
        idle_q <= idle_q + 8'h1;
      if (!boot_q) begin
        case (mode_q)
          `SCMC_MODE_SLAVE, `SCMC_MODE_MASTER: begin
            if (cmd_mode_o && cmd_done_i && cmd_connect_i && !link_up_i)
              connect_req_o <= 1'b1;
            if (mode_q == `SCMC_MODE_MASTER && break_seen_i && link_up_i)
              disconnect_req_o <= 1'b1;
          end
          `SCMC_MODE_TRIGGER: begin
            if (rx_valid_i && !link_up_i && !cmd_mode_o)
              connect_req_o <= 1'b1;
            if (link_up_i && (break_seen_i || idle_q >= idle_set_q))
              disconnect_req_o <= 1'b1;
          end
          `SCMC_MODE_AUTO: begin
            // break characters never drop this link
            if (!link_up_i) begin
              if (remote_address_valid_i)
                connect_req_o <= 1'b1;
              else begin
                inquiry_req_o <= 1'b1;
                if (inquiry_found_i)
                  store_address_o <= 1'b1;
              end
            end
          end
          `SCMC_MODE_PIN: begin
            if (connect_control_pin_i && !link_up_i)
              connect_req_o <= 1'b1;
            if (!connect_control_pin_i && link_up_i)
              disconnect_req_o <= 1'b1;
          end
          `SCMC_MODE_ANY: begin
            if (connect_control_pin_i && !pin_q)
              inquiry_req_o <= 1'b1;
            if (inquiry_found_i && !link_up_i)
              connect_req_o <= 1'b1;
            if (!connect_control_pin_i && link_up_i)
              disconnect_req_o <= 1'b1;
          end
          `SCMC_MODE_PAIR: begin
            if (!link_up_i && remote_address_valid_i)
              connect_req_o <= 1'b1;
          end
          default: connect_req_o <= 1'b0;
        endcase
      end
    end
  end

  // limitation: the reply code says which string to send, not the
  // string itself; the uart transmitter expands it into characters

endmodule // scmc_ctrl

// ===== tb/scmc_ctrl_assertions.sv
module scmc_ctrl_assertions #(
  parameter BAUD_DEF = 115200
) (
  input wire        core_clk_i,
  input wire        rst_i,
  input wire        rx_valid_i,
  input wire [7:0]  rx_data_i,
  input wire        cmd_done_i,
  input wire [2:0]  cmd_class_i,
  input wire        link_up_i,
  input wire        connect_control_pin_i,
  input wire        tx_valid_o,
  input wire [7:0]  tx_data_o,
  input wire        reply_valid_o,
  input wire [2:0]  reply_code_o,
  input wire        cmd_mode_o,
  input wire        fast_data_o,
  input wire        connect_req_o,
  input wire        disconnect_req_o,
  input wire        discoverable_o,
  input wire        remote_config_ok_o,
  input wire [2:0]  active_mode_o,
  input wire [31:0] baud_rate_o
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (rst_i);
  ////////////////////////////////////////
  // byte patterns seen on the receive stream
  sequence s_byte(b);
    rx_valid_i && rx_data_i == b;
  endsequence
  sequence s_escape;
    s_byte(8'h24) ##1 s_byte(8'h24) ##1 s_byte(8'h24);
  endsequence
  sequence s_exit;
    s_byte(8'h2d) ##1 s_byte(8'h2d) ##1 s_byte(8'h2d) ##1 s_byte(8'h0d);
  endsequence
  // entry only where nothing forbids it; auto modes refuse even unlinked
  a_escape_enters_cmd: assert property (
    (s_escape ##0 (!cmd_mode_o && !fast_data_o && !link_up_i && active_mode_o != 3'h3
      && active_mode_o != 3'h4 && active_mode_o != 3'h5))
    |=> cmd_mode_o && reply_valid_o && reply_code_o == 3'h1) else $error("escape ignored");
  a_escape_refused: assert property (
    (s_escape ##0 (!cmd_mode_o && (fast_data_o || link_up_i && active_mode_o >= 3'h3
      && active_mode_o <= 3'h5))) |=> !cmd_mode_o) else $error("escape not refused");
  a_reply_by_class: assert property (
    cmd_done_i && cmd_mode_o && cmd_class_i <= 3'h4
    |=> reply_valid_o && reply_code_o == $past(cmd_class_i) + 3'h2) else $error("bad reply");
  a_exit_to_data: assert property (
    (s_exit ##0 cmd_mode_o) |=> !cmd_mode_o && reply_valid_o && reply_code_o == 3'h7)
    else $error("exit failed");
  a_fast_data_sticky: assert property (
    fast_data_o |=> fast_data_o && !cmd_mode_o) else $error("fast data left");
  a_prefix_forwarded: assert property (
    (s_byte(8'h24) ##1 (rx_valid_i && rx_data_i != 8'h24 && !cmd_mode_o))
    |=> tx_valid_o && tx_data_o == $past(rx_data_i)) else $error("broken prefix lost");
  a_master_hidden: assert property (
    (active_mode_o == 3'h1 || active_mode_o >= 3'h3 && active_mode_o <= 3'h5)[*4]
    |-> !discoverable_o && !remote_config_ok_o) else $error("master mode visible");
  a_slave_visible: assert property (
    (active_mode_o == 3'h0 && !link_up_i)[*4] |-> discoverable_o) else $error("slave hidden");
  a_baud_default: assert property (
    (!rst_i)[*4] |-> baud_rate_o == BAUD_DEF) else $error("wrong baud rate");
  a_trigger_connect: assert property (
    active_mode_o == 3'h2 && !link_up_i && rx_valid_i && rx_data_i != 8'h24 && !cmd_mode_o
    |-> ##[1:2] connect_req_o) else $error("trigger did not connect");
  a_pin_low_drops: assert property (
    $fell(connect_control_pin_i) && link_up_i && active_mode_o == 3'h4
    |-> ##[1:2] disconnect_req_o) else $error("pin low kept link");
endmodule // scmc_ctrl_assertions

// ===== tb/scmc_host_model.sv
module scmc_host_model (
  output logic       rx_valid_o,
  output logic [7:0] rx_data_o,
  output logic       pin_o,
  input  wire        core_clk_i
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    rx_valid_o = 1'b0;
    rx_data_o = 8'h00;
    pin_o = 1'b0;
  end
  ////////////////////////////////////////
  // one byte per edge, so back-to-back calls form a burst
  task send(input logic [7:0] b);
    @(posedge core_clk_i);
    rx_valid_o <= 1'b1;
    rx_data_o <= b;
  endtask
  // released data shows the inverse, so a stale byte never looks valid
  task idle();
    @(posedge core_clk_i);
    rx_valid_o <= 1'b0;
    rx_data_o <= ~rx_data_o;
  endtask
  // the host owns the connect control pin
  task pin(input logic v);
    @(posedge core_clk_i);
    pin_o <= v;
  endtask
endmodule // scmc_host_model

// ===== tb/scmc_ctrl_tb_top.sv
module scmc_ctrl_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic        core_clk_i = 1'b0;
  logic        rst_i = 1'b1;
  logic        rx_valid, pin, tx_valid, reply_valid, cmd_mode, fast_data, conn, disc;
  logic        cmd_done = 1'b0;
  logic        cmd_conn = 1'b0;
  logic        brk = 1'b0;
  logic        found = 1'b0;
  logic        addr_ok = 1'b1;
  logic        inq, store, seen_i, seen_s;
  logic [7:0]  idle_set = 8'h05;
  logic        link = 1'b0;
  logic        discov, rcfg, seen_c, seen_d;
  logic [2:0]  cmd_class = 3'h0;
  logic [2:0]  mode = 3'h0;
  logic [2:0]  reply_code, last_rpl, act_mode;
  logic [7:0]  cto = 8'hff;
  logic [7:0]  rx_data, tx_data, last_tx;
  logic [31:0] baud;
  logic [15:0] seed = 16'hd97b;
  int          errors = 0;
  int          n_compared = 0;
  always #20 core_clk_i = ~core_clk_i;
  ////////////////////////////////////////
  // short second so the window runs out in tens of cycles
  scmc_ctrl #(.CLK_HZ(16)) dut_u (.core_clk_i(core_clk_i), .rst_i(rst_i),
    .rx_valid_i(rx_valid), .rx_data_i(rx_data), .cmd_done_i(cmd_done),
    .cmd_class_i(cmd_class), .cmd_connect_i(cmd_conn), .operating_mode_select_i(mode),
    .config_timeout_set_i(cto), .idle_timeout_set_i(idle_set),
    .remote_address_valid_i(addr_ok),
    .break_seen_i(brk), .link_up_i(link), .inquiry_found_i(found),
    .connect_control_pin_i(pin), .tx_valid_o(tx_valid), .tx_data_o(tx_data),
    .reply_valid_o(reply_valid), .reply_code_o(reply_code), .cmd_mode_o(cmd_mode),
    .fast_data_o(fast_data), .connect_req_o(conn), .disconnect_req_o(disc),
    .inquiry_req_o(inq), .store_address_o(store), .discoverable_o(discov),
    .remote_config_ok_o(rcfg), .active_mode_o(act_mode), .baud_rate_o(baud));
  scmc_host_model host_u (.rx_valid_o(rx_valid), .rx_data_o(rx_data), .pin_o(pin),
    .core_clk_i(core_clk_i));
  // pulses are latched so the sequence can inspect them later
  always @(posedge core_clk_i) begin
    if (rst_i) begin
      {seen_c, seen_d, seen_i, seen_s, last_rpl, last_tx} <= '0;
    end else begin
      if (reply_valid) last_rpl <= reply_code;
      if (tx_valid) last_tx <= tx_data;
      if (conn) seen_c <= 1'b1;
      if (disc) seen_d <= 1'b1;
      if (inq) seen_i <= 1'b1;
      if (store) seen_s <= 1'b1;
    end
  end
  function automatic logic [15:0] lfsr(input logic [15:0] x);
    return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
  endfunction
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      errors++;
      $display("Error at %0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask
  task print_verdict();
    if (errors == 0 && n_compared > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  // step past the edge so latched values have landed
  task settle(input int n);
    repeat (n) @(posedge core_clk_i);
    #1;
  endtask
  task do_reset(input logic [2:0] m, input logic [7:0] t);
    @(posedge core_clk_i);
    rst_i <= 1'b1;
    mode <= m;
    cto <= t;
    link <= 1'b0;
    found <= 1'b0;
    brk <= 1'b0;
    cmd_conn <= 1'b0;
    repeat (12) @(posedge core_clk_i);
    rst_i <= 1'b0;
    settle(3);
  endtask
  task esc();
    repeat (3) host_u.send(8'h24);
    host_u.idle();
    settle(2);
  endtask
  // watchdog far beyond the expected few hundred cycles
  initial begin
    repeat (20000) @(posedge core_clk_i);
    errors++;
    print_verdict();
  end
  initial begin
    int i;
    logic [7:0] b;
    do_reset(3'h0, 8'hff);
    chk(baud, 115200);
    chk(discov, 1);
    esc();
    chk(cmd_mode, 1);
    chk(last_rpl, 1);
    for (i = 0; i < 5; i++) begin
      @(posedge core_clk_i);
      cmd_done <= 1'b1;
      cmd_class <= i[2:0];
      @(posedge core_clk_i);
      cmd_done <= 1'b0;
      settle(2);
      chk(last_rpl, i + 2);
    end
    repeat (3) host_u.send(8'h2d);
    host_u.send(8'h0d);
    host_u.idle();
    settle(2);
    chk(cmd_mode, 0);
    chk(last_rpl, 7);
    // random bytes after one or two escape characters
    for (i = 0; i < 8; i++) begin
      seed = lfsr(seed);
      b = (seed[7:0] == 8'h24) ? 8'h25 : seed[7:0];
      if (i[0]) host_u.send(8'h24);
      host_u.send(8'h24);
      host_u.send(b);
      host_u.idle();
      settle(2);
      chk(last_tx, b);
      chk(cmd_mode, 0);
    end
    for (i = 1; i < 8; i++) begin
      do_reset(i[2:0], 8'hff);
      chk(act_mode, (i == 7) ? 0 : i);
      if (i == 1 || (i >= 3 && i <= 5)) chk(discov | rcfg, 0);
    end
    do_reset(3'h2, 8'hff);
    host_u.send(8'h41);
    host_u.idle();
    settle(3);
    chk(seen_c, 1);
    do_reset(3'h4, 8'hff);
    host_u.pin(1'b1);
    settle(3);
    chk(seen_c, 1);
    link <= 1'b1;
    host_u.pin(1'b0);
    settle(3);
    chk(seen_d, 1);
    esc();
    chk(cmd_mode, 0);
    do_reset(3'h0, 8'h02);
    link <= 1'b1;
    esc();
    chk(cmd_mode, 1);
    do_reset(3'h0, 8'h02);
    settle(40);
    chk(fast_data, 1);
    esc();
    chk(cmd_mode, 0);
    do_reset(3'h0, 8'hff);
    settle(40);
    chk(fast_data, 0);
    link <= 1'b1;
    esc();
    chk(cmd_mode, 1);
    // master dials on a connect line and hangs up on break
    do_reset(3'h1, 8'hff);
    esc();
    @(posedge core_clk_i);
    cmd_done <= 1'b1;
    cmd_conn <= 1'b1;
    @(posedge core_clk_i);
    cmd_done <= 1'b0;
    settle(2);
    chk(seen_c, 1);
    link <= 1'b1;
    brk <= 1'b1;
    settle(2);
    chk(seen_d, 1);
    // trigger link drops only after the idle timeout
    do_reset(3'h2, 8'hff);
    link <= 1'b1;
    settle(40);
    chk(seen_d, 0);
    settle(60);
    chk(seen_d, 1);
    // auto master without an address searches, stores only a find
    addr_ok <= 1'b0;
    do_reset(3'h3, 8'hff);
    chk(seen_i, 1);
    chk(seen_s, 0);
    found <= 1'b1;
    settle(2);
    chk(seen_s, 1);
    addr_ok <= 1'b1;
    // any mode: pin rise searches and dials the find, never stores it
    do_reset(3'h5, 8'hff);
    found <= 1'b1;
    host_u.pin(1'b1);
    settle(3);
    chk(seen_i, 1);
    chk(seen_c, 1);
    chk(seen_s, 0);
    print_verdict();
  end
endmodule // scmc_ctrl_tb_top
bind scmc_ctrl scmc_ctrl_assertions #(.BAUD_DEF(BAUD_DEF)) chk_u (.core_clk_i(core_clk_i),
  .rst_i(rst_i), .rx_valid_i(rx_valid_i), .rx_data_i(rx_data_i), .cmd_done_i(cmd_done_i),
  .cmd_class_i(cmd_class_i), .link_up_i(link_up_i), .tx_valid_o(tx_valid_o),
  .connect_control_pin_i(connect_control_pin_i), .tx_data_o(tx_data_o),
  .reply_valid_o(reply_valid_o), .reply_code_o(reply_code_o), .cmd_mode_o(cmd_mode_o),
  .fast_data_o(fast_data_o), .connect_req_o(connect_req_o), .baud_rate_o(baud_rate_o),
  .disconnect_req_o(disconnect_req_o), .discoverable_o(discoverable_o),
  .remote_config_ok_o(remote_config_ok_o), .active_mode_o(active_mode_o));
